//--- hdl/osc_alu.sv
// Purpose: decimal fixed point arithmetic with the point after the first digit
// Assumes: operands below ten in magnitude, shift counts above eleven act as eleven
// Notes: combinational; the core registers the result
`timescale 1ns/1ns
module osc_alu (
  // operand and result carrier
  osc_alu_if.alu bus
);
  // packed decimal word to binary
  function automatic logic [79:0] toBin(input logic [47:0] w);
    logic [79:0] v;
    v = '0;
    for (int i = osc_pkg::DIGITS - 1; i >= 0; i--) begin
      v = v * osc_pkg::BIN_TEN + {76'h0, w[i*4 +: 4]};
    end
    return v;
  endfunction

  // binary to packed decimal word, low twelve digits only
  function automatic logic [47:0] toWord(input logic [79:0] v);
    logic [79:0] r;
    logic [47:0] w;
    r = v;
    w = '0;
    for (int i = 0; i < osc_pkg::DIGITS; i++) begin
      w[i*4 +: 4] = 4'(r % osc_pkg::BIN_TEN);
      r = r / osc_pkg::BIN_TEN;
    end
    return w;
  endfunction

  // power of ten for decimal shifts
  function automatic logic [79:0] pow10(input logic [3:0] n);
    logic [79:0] p;
    p = osc_pkg::BIN_ONE;
    for (int i = 0; i < osc_pkg::DIGITS; i++) begin
      if (4'(i) < n) begin
        p = p * osc_pkg::BIN_TEN;
      end
    end
    return p;
  endfunction

  // arithmetic by operation
  always_comb begin
    logic [79:0] a;
    logic [79:0] b;
    logic [79:0] mag;
    logic [3:0] n;
    logic bNeg;
    logic neg;
    a = toBin(bus.accWord);
    b = toBin(bus.opdWord);
    n = (bus.shiftCount > osc_pkg::SHIFT_MAX) ? osc_pkg::SHIFT_MAX : bus.shiftCount;
    bNeg = (bus.op == osc_pkg::OP_SUB) ? !bus.opdNeg : bus.opdNeg;
    mag = a;
    neg = bus.accNeg;
    bus.overflow = 1'b0;
    case (bus.op)
      osc_pkg::OP_ADD, osc_pkg::OP_SUB: begin
        if (bus.accNeg == bNeg) begin
          mag = a + b;
        end else if (a >= b) begin
          mag = a - b;
        end else begin
          mag = b - a;
          neg = bNeg;
        end
        bus.overflow = mag >= osc_pkg::WORD_LIMIT;
      end
      osc_pkg::OP_MUL: begin
        // scales add, so the product is pulled right; excess digits fall off unflagged
        mag = (a * b) / osc_pkg::POINT_SCALE;
        neg = bus.accNeg ^ bus.opdNeg;
      end
      osc_pkg::OP_DIV: begin
        neg = bus.accNeg ^ bus.opdNeg;
        if (b == '0) begin
          mag = '0;
          bus.overflow = 1'b1;
        end else begin
          mag = (a * osc_pkg::POINT_SCALE) / b;
          bus.overflow = mag >= osc_pkg::WORD_LIMIT;
        end
      end
      osc_pkg::OP_SHL: mag = a * pow10(n);
      osc_pkg::OP_SHR: mag = a / pow10(n);
      default: mag = a;
    endcase
    // twelve digits plus sign are kept
    bus.resWord = toWord(mag % osc_pkg::WORD_LIMIT);
    bus.resNeg = neg;
  end
endmodule

//--- hdl/osc_alu_if.sv
// Purpose: carries operands and results between the control core and the arithmetic unit
// Assumes: one clock, purely combinational unit on the far side
// Notes: words are packed decimal, sign held apart
`timescale 1ns/1ns
interface osc_alu_if;
  // operation and operands
  osc_pkg::osc_op_type op;
  logic [47:0] accWord;
  logic accNeg;
  logic [47:0] opdWord;
  logic opdNeg;
  logic [3:0] shiftCount;
  // result
  logic [47:0] resWord;
  logic resNeg;
  logic overflow;
  modport core (output op, accWord, accNeg, opdWord, opdNeg, shiftCount,
    input resWord, resNeg, overflow);
  modport alu (input op, accWord, accNeg, opdWord, opdNeg, shiftCount,
    output resWord, resNeg, overflow);
endinterface

//--- hdl/osc_ctl.sv
// Purpose: index switch setting, column selector operand, carriage interlock, overflow alarm
// Assumes: sequencer offers one instruction at a time with instValid while instReady
// Notes: carriage pins are asynchronous and pass two flip-flops first
// Behaviour
// - accumulator-to-first-index adds the low accumulator digit to the first index
// - accumulator-to-second-index adds the low accumulator digit to the second index
// - combined instruction adds the low accumulator digit to both indexes
// - column selector presents a digit zero to nine at every tab stop
// - selector-named instructions use the selector value as operand digit
// - selector is never used while the carriage travels
// - with selector fitted, hold next start after print or key until arrival
// - without selector, continue while the carriage still moves
// - words hold twelve digits plus sign, point after the first digit
// - keyboard entries sit with the point at the left of eleven columns
// - add, subtract, divide raise the alarm when magnitude reaches ten
// - multiplication never alarms; right-hand excess digits are dropped silently
// - left and right shifts move the accumulator by a programmed count
// - product scale is the sum of factor scales, shifting it right
`timescale 1ns/1ns
module osc_ctl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // instruction sequencer
  input wire logic instValid,
  input wire osc_pkg::osc_op_type instOp,
  input wire logic [3:0] instDigit,
  input wire logic instUseSel,
  input wire logic [47:0] memWord,
  input wire logic memNeg,
  output logic instReady,
  output logic instDone,
  // operator keyboard
  input wire logic [43:0] kbdDigits,
  input wire logic kbdNeg,
  // carriage and control panel
  input wire logic carriageMoving,
  input wire logic [3:0] columnSel,
  input wire logic selectorFitted,
  output logic carriageGo,
  // machine state
  output logic [47:0] accDigits,
  output logic accNeg,
  output logic [3:0] firstIdx,
  output logic [3:0] secondIdx,
  output logic overflowAlarm,
  input wire logic alarmClear
);
  typedef struct packed {
    osc_pkg::osc_state_type st;
    osc_pkg::osc_op_type op;
    logic [3:0] digit;
    logic useSel;
    logic [47:0] opd;
    logic opdNeg;
    logic [47:0] acc;
    logic accNeg;
    logic [3:0] firstIdx;
    logic [3:0] secondIdx;
    logic alarm;
    logic ready;
    logic done;
    logic carriageGo;
    logic movMeta;
    logic movSync;
    logic [3:0] selMeta;
    logic [3:0] selSync;
  } osc_core_type;

  osc_core_type q;
  osc_core_type d;
  logic stall;
  logic [3:0] opDigit;
  osc_alu_if aluBus ();

  // decimal switch step, wraps past nine
  function automatic logic [3:0] addDigit(input logic [3:0] sw, input logic [3:0] inc);
    logic [4:0] s;
    s = {1'b0, sw} + {1'b0, inc};
    if (s >= osc_pkg::DIGIT_RADIX) begin
      s = s - osc_pkg::DIGIT_RADIX;
    end
    return s[3:0];
  endfunction

  // arithmetic unit
  osc_alu aluInst (
    .bus(aluBus.alu)
  );

  // operand digit, from the selector or the instruction, kept within one digit
  always_comb begin
    logic [3:0] raw;
    raw = q.useSel ? q.selSync : q.digit;
    opDigit = (raw > osc_pkg::DIGIT_MAX) ? osc_pkg::DIGIT_MAX : raw;
  end

  // no selector use while the carriage is between stops
  assign stall = q.useSel && q.movSync;

  // arithmetic operands
  assign aluBus.op = q.op;
  assign aluBus.accWord = q.acc;
  assign aluBus.accNeg = q.accNeg;
  assign aluBus.opdWord = q.opd;
  assign aluBus.opdNeg = q.opdNeg;
  assign aluBus.shiftCount = opDigit;

  // next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.carriageGo = 1'b0;
    d.movMeta = carriageMoving;
    d.movSync = q.movMeta;
    d.selMeta = columnSel;
    d.selSync = q.selMeta;
    if (alarmClear) begin
      d.alarm = 1'b0;
    end
    unique case (q.st)
      osc_pkg::ST_IDLE: begin
        if (instValid && q.ready) begin
          d.op = instOp;
          d.digit = instDigit;
          d.useSel = instUseSel;
          d.opd = memWord;
          d.opdNeg = memNeg;
          d.ready = 1'b0;
          d.st = osc_pkg::ST_EXEC;
        end
      end
      osc_pkg::ST_EXEC: begin
        if (!stall) begin
          d.done = 1'b1;
          d.ready = 1'b1;
          d.st = osc_pkg::ST_IDLE;
          case (q.op)
            osc_pkg::OP_ADD, osc_pkg::OP_SUB, osc_pkg::OP_DIV, osc_pkg::OP_MUL,
            osc_pkg::OP_SHL, osc_pkg::OP_SHR: begin
              d.acc = aluBus.resWord;
              d.accNeg = aluBus.resNeg;
              if (aluBus.overflow) begin
                d.alarm = 1'b1;
              end
            end
            osc_pkg::OP_KEY: begin
              d.acc = {osc_pkg::DIGIT_ZERO, kbdDigits};
              d.accNeg = kbdNeg;
            end
            osc_pkg::OP_ACC_FIRST: d.firstIdx = addDigit(q.firstIdx, q.acc[3:0]);
            osc_pkg::OP_ACC_SECOND: d.secondIdx = addDigit(q.secondIdx, q.acc[3:0]);
            osc_pkg::OP_ACC_BOTH: begin
              d.firstIdx = addDigit(q.firstIdx, q.acc[3:0]);
              d.secondIdx = addDigit(q.secondIdx, q.acc[3:0]);
            end
            osc_pkg::OP_HOME_FIRST: d.firstIdx = opDigit;
            osc_pkg::OP_HOME_SECOND: d.secondIdx = opDigit;
            default: d.acc = q.acc;
          endcase
          // print and key move the carriage on
          if (q.op == osc_pkg::OP_KEY || q.op == osc_pkg::OP_PRINT) begin
            d.carriageGo = 1'b1;
            if (selectorFitted) begin
              d.ready = 1'b0;
              d.st = osc_pkg::ST_WAIT_LEAVE;
            end
          end
        end
      end
      osc_pkg::ST_WAIT_LEAVE: begin
        if (q.movSync) begin
          d.st = osc_pkg::ST_WAIT_ARRIVE;
        end
      end
      osc_pkg::ST_WAIT_ARRIVE: begin
        if (!q.movSync) begin
          d.ready = 1'b1;
          d.st = osc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign instReady = q.ready;
  assign instDone = q.done;
  assign carriageGo = q.carriageGo;
  assign accDigits = q.acc;
  assign accNeg = q.accNeg;
  assign firstIdx = q.firstIdx;
  assign secondIdx = q.secondIdx;
  assign overflowAlarm = q.alarm;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic execNow;
  assign execNow = (q.st == osc_pkg::ST_EXEC) && !stall;

  chk_first_index_add: assert property (
    execNow && q.op == osc_pkg::OP_ACC_FIRST |=>
      firstIdx == addDigit($past(q.firstIdx), $past(q.acc[3:0])) && $stable(secondIdx))
    else $error("first index not advanced by accumulator digit");
  chk_second_index_add: assert property (
    execNow && q.op == osc_pkg::OP_ACC_SECOND |=>
      secondIdx == addDigit($past(q.secondIdx), $past(q.acc[3:0])) && $stable(firstIdx))
    else $error("second index not advanced by accumulator digit");
  chk_both_index_add: assert property (
    execNow && q.op == osc_pkg::OP_ACC_BOTH |=>
      firstIdx == addDigit($past(q.firstIdx), $past(q.acc[3:0])) &&
      secondIdx == addDigit($past(q.secondIdx), $past(q.acc[3:0])))
    else $error("indexes not both advanced");
  chk_selector_operand: assert property (
    execNow && q.useSel && q.op == osc_pkg::OP_HOME_FIRST && q.selSync <= osc_pkg::DIGIT_MAX
      |=> firstIdx == $past(q.selSync))
    else $error("selector value not used as operand");
  chk_travel_hold: assert property (
    q.st == osc_pkg::ST_EXEC && stall |=> q.st == osc_pkg::ST_EXEC && !instDone &&
      $stable(firstIdx) && $stable(accDigits))
    else $error("selector used during carriage travel");
  chk_interlock_hold: assert property (
    execNow && (q.op == osc_pkg::OP_PRINT || q.op == osc_pkg::OP_KEY) && selectorFitted
      |=> !instReady && q.st == osc_pkg::ST_WAIT_LEAVE)
    else $error("start not held after print or key");
  chk_interlock_wait: assert property (
    (q.st == osc_pkg::ST_WAIT_LEAVE || q.st == osc_pkg::ST_WAIT_ARRIVE) |-> !instReady)
    else $error("start allowed while carriage not arrived");
  chk_interlock_release: assert property (
    q.st == osc_pkg::ST_WAIT_ARRIVE && !q.movSync |=> instReady)
    else $error("start not released after carriage arrival");
  chk_no_interlock: assert property (
    execNow && (q.op == osc_pkg::OP_PRINT || q.op == osc_pkg::OP_KEY) && !selectorFitted
      |=> instReady && carriageGo)
    else $error("program held without selector fitted");
  chk_keyboard_align: assert property (
    execNow && q.op == osc_pkg::OP_KEY |=> accDigits[47:44] == osc_pkg::DIGIT_ZERO)
    else $error("keyboard entry not aligned at the point");
  chk_overflow_alarm: assert property (
    execNow && aluBus.overflow &&
      (q.op == osc_pkg::OP_ADD || q.op == osc_pkg::OP_SUB || q.op == osc_pkg::OP_DIV)
      |=> overflowAlarm)
    else $error("overflow alarm missing");
  chk_mul_no_alarm: assert property (
    execNow && q.op == osc_pkg::OP_MUL |=> overflowAlarm == ($past(q.alarm) && !$past(alarmClear)))
    else $error("multiplication raised alarm");
  chk_index_range: assert property (
    firstIdx <= osc_pkg::DIGIT_MAX && secondIdx <= osc_pkg::DIGIT_MAX)
    else $error("index switch out of digit range");

  cov_interlock_wait: cover property (q.st == osc_pkg::ST_WAIT_ARRIVE ##1 instReady);
  cov_mul_done: cover property (execNow && q.op == osc_pkg::OP_MUL);
  cov_alarm_raised: cover property (!overflowAlarm ##1 overflowAlarm);
  cov_selector_stall: cover property (q.st == osc_pkg::ST_EXEC && stall);
endmodule

//--- hdl/osc_pkg.sv
// Purpose: shared constants and types of the operand switch and overflow control
// Assumes: words are twelve packed decimal digits, most significant digit first
// Notes: binary figures are used only inside the arithmetic unit
package osc_pkg;
  // word layout
  localparam int DIGITS = 12;
  localparam int WORD_W = 48;
  localparam int KBD_W = 44;
  localparam int BIN_W = 80;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] SHIFT_MAX = 4'hB;
  localparam logic [4:0] DIGIT_RADIX = 5'hA;
  // binary scale figures
  localparam logic [79:0] BIN_ONE = 80'h1;
  localparam logic [79:0] BIN_TEN = 80'hA;
  localparam logic [79:0] WORD_LIMIT = 80'hE8D4A51000;
  localparam logic [79:0] POINT_SCALE = 80'h174876E800;
  // instructions seen by this block
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SHL, OP_SHR, OP_KEY, OP_PRINT,
    OP_ACC_FIRST, OP_ACC_SECOND, OP_ACC_BOTH, OP_HOME_FIRST, OP_HOME_SECOND
  } osc_op_type;
  // sequencing states
  typedef enum logic [1:0] {
    ST_IDLE, ST_EXEC, ST_WAIT_LEAVE, ST_WAIT_ARRIVE
  } osc_state_type;
endpackage

//--- verif/osc_carriage_model.sv
// Purpose: carriage and control panel on the far side of the block
// Assumes: one move per carriageGo pulse, moves queue while one travels
// Notes: selector shows a changing pattern while the carriage travels
`timescale 1ns/1ns
module osc_carriage_model #(
  parameter logic [15:0] COLS = 16'h9683,
  parameter int TRAVEL = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // carriage request
  input wire logic carriageGo,
  // carriage pins
  output logic carriageMoving,
  output logic [3:0] columnSel,
  output logic busy
);
  int pend;
  int cnt;
  logic [1:0] col;
  logic start;
  // a queued move starts once the carriage rests
  assign start = !carriageMoving && pend != 0;
  assign busy = carriageMoving || pend != 0;
  // pins change just after the edge
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pend <= 0;
      cnt <= 0;
      col <= 2'h0;
      carriageMoving <= 1'b0;
      columnSel <= COLS[3:0];
    end else begin
      pend <= pend + int'(carriageGo) - int'(start);
      if (start) begin
        carriageMoving <= 1'b1;
        cnt <= TRAVEL;
        col <= col + 2'h1;
      end else if (carriageMoving) begin
        cnt <= cnt - 1;
        columnSel <= ~columnSel; // no value between stops
        if (cnt == 1) begin
          carriageMoving <= 1'b0;
          columnSel <= COLS[{col, 2'b00} +: 4]; // digit set per column
        end
      end
    end
  end
endmodule

//--- verif/tb_operand_switch_and_overflow_ctl.sv
// Purpose: self-checking bench of the operand switch and overflow control
// Assumes: instructions offered one at a time, waiting for instDone
// Notes: carriage model advances one column per print or key
`timescale 1ns/1ns
module tb_operand_switch_and_overflow_ctl;
  localparam logic [15:0] COLS = 16'h9683;
  logic sys_clk, rst_n, instValid, instUseSel, memNeg, instReady, instDone, kbdNeg;
  logic carriageMoving, selectorFitted, carriageGo, accNeg, overflowAlarm, alarmClear, busy;
  osc_pkg::osc_op_type instOp;
  logic [3:0] instDigit, columnSel, firstIdx, secondIdx;
  logic [47:0] memWord, accDigits;
  logic [43:0] kbdDigits;
  logic [1:0] mv = 2'h0;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  osc_ctl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .instValid(instValid), .instOp(instOp),
    .instDigit(instDigit), .instUseSel(instUseSel), .memWord(memWord), .memNeg(memNeg),
    .instReady(instReady), .instDone(instDone), .kbdDigits(kbdDigits), .kbdNeg(kbdNeg),
    .carriageMoving(carriageMoving), .columnSel(columnSel), .selectorFitted(selectorFitted),
    .carriageGo(carriageGo), .accDigits(accDigits), .accNeg(accNeg), .firstIdx(firstIdx),
    .secondIdx(secondIdx), .overflowAlarm(overflowAlarm), .alarmClear(alarmClear));
  osc_carriage_model #(.COLS(COLS), .TRAVEL(8)) i_car (.sys_clk(sys_clk), .rst_n(rst_n),
    .carriageGo(carriageGo), .carriageMoving(carriageMoving), .columnSel(columnSel),
    .busy(busy));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // offer one instruction, hold it to the take edge, wait for done
  task automatic op(input osc_pkg::osc_op_type o, input logic [3:0] d, input logic s,
    input logic [47:0] m, input logic n);
    int k;
    k = 0;
    @(posedge sys_clk);
    instValid <= 1'b1;
    instOp <= o;
    instDigit <= d;
    instUseSel <= s;
    memWord <= m;
    memNeg <= n;
    @(posedge sys_clk);
    while (instReady !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    instValid <= 1'b0;
    #1;
    k = 0;
    while (instDone !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(instDone, 1'b1);
    chk(carriageGo, 1'(o == osc_pkg::OP_KEY || o == osc_pkg::OP_PRINT));
    if (o == osc_pkg::OP_KEY || o == osc_pkg::OP_PRINT) mv = mv + 2'h1;
  endtask
  task automatic ar(input osc_pkg::osc_op_type o, input logic [3:0] d,
    input logic [47:0] m, input logic n, input logic [47:0] ea, input logic en, eal);
    op(o, d, 1'b0, m, n);
    chk(accDigits, ea);
    chk(accNeg, en);
    chk(overflowAlarm, eal);
  endtask
  task clr;
    @(posedge sys_clk);
    alarmClear <= 1'b1;
    @(posedge sys_clk);
    alarmClear <= 1'b0;
    #1;
    chk(overflowAlarm, 1'b0);
  endtask
  task automatic idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
  endtask
  // carriage interlock watch and run ceiling
  always @(posedge sys_clk) begin
    cyc++;
    if (rst_n && selectorFitted && carriageMoving) chk(instReady, 1'b0);
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    rst_n <= 1'b0;
    instValid <= 1'b0;
    instOp <= osc_pkg::OP_NOP;
    instDigit <= 4'h0;
    instUseSel <= 1'b0;
    memWord <= 48'h0;
    memNeg <= 1'b0;
    kbdDigits <= 44'h12345678907;
    kbdNeg <= 1'b0;
    selectorFitted <= 1'b0;
    alarmClear <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(instReady, 1'b1);
    chk(accDigits, 48'h0);
    op(osc_pkg::OP_KEY, 4'h0, 1'b0, 48'h0, 1'b0);
    chk(accDigits, 48'h012345678907);
    op(osc_pkg::OP_HOME_FIRST, 4'h0, 1'b0, 48'h0, 1'b0);
    op(osc_pkg::OP_ACC_FIRST, 4'h0, 1'b0, 48'h0, 1'b0);
    chk(firstIdx, 4'h7);
    op(osc_pkg::OP_HOME_SECOND, 4'h5, 1'b0, 48'h0, 1'b0);
    op(osc_pkg::OP_ACC_SECOND, 4'h0, 1'b0, 48'h0, 1'b0);
    chk(secondIdx, 4'h2);
    op(osc_pkg::OP_ACC_BOTH, 4'h0, 1'b0, 48'h0, 1'b0);
    chk(firstIdx, 4'h4);
    chk(secondIdx, 4'h9);
    op(osc_pkg::OP_HOME_FIRST, 4'hC, 1'b0, 48'h0, 1'b0);
    chk(firstIdx, 4'h9);
    ar(osc_pkg::OP_SHR, 4'h2, 48'h0, 1'b0, 48'h000123456789, 1'b0, 1'b0);
    ar(osc_pkg::OP_SHL, 4'h1, 48'h0, 1'b0, 48'h001234567890, 1'b0, 1'b0);
    @(posedge sys_clk);
    kbdDigits <= 44'h50000000000;
    op(osc_pkg::OP_KEY, 4'h0, 1'b0, 48'h0, 1'b0);
    chk(accDigits, 48'h050000000000);
    ar(osc_pkg::OP_SHL, 4'h1, 48'h0, 1'b0, 48'h500000000000, 1'b0, 1'b0);
    ar(osc_pkg::OP_ADD, 4'h0, 48'h500000000000, 1'b0, 48'h0, 1'b0, 1'b1);
    ar(osc_pkg::OP_ADD, 4'h0, 48'h400000000000, 1'b0, 48'h400000000000, 1'b0, 1'b1);
    clr();
    ar(osc_pkg::OP_SUB, 4'h0, 48'h700000000000, 1'b0, 48'h300000000000, 1'b1, 1'b0);
    ar(osc_pkg::OP_SUB, 4'h0, 48'h700000000000, 1'b1, 48'h400000000000, 1'b0, 1'b0);
    ar(osc_pkg::OP_SUB, 4'h0, 48'h700000000000, 1'b1, 48'h100000000000, 1'b0, 1'b1);
    clr();
    ar(osc_pkg::OP_MUL, 4'h0, 48'h250000000000, 1'b0, 48'h250000000000, 1'b0, 1'b0);
    ar(osc_pkg::OP_MUL, 4'h0, 48'h900000000000, 1'b1, 48'h250000000000, 1'b1, 1'b0);
    ar(osc_pkg::OP_MUL, 4'h0, 48'h12, 1'b1, 48'h30, 1'b0, 1'b0);
    @(posedge sys_clk);
    kbdDigits <= 44'h10000000000;
    op(osc_pkg::OP_KEY, 4'h0, 1'b0, 48'h0, 1'b0);
    ar(osc_pkg::OP_DIV, 4'h0, 48'h200000000000, 1'b0, 48'h005000000000, 1'b0, 1'b0);
    ar(osc_pkg::OP_DIV, 4'h0, 48'h1, 1'b0, 48'h0, 1'b0, 1'b1);
    clr();
    ar(osc_pkg::OP_DIV, 4'h0, 48'h0, 1'b0, 48'h0, 1'b0, 1'b1);
    clr();
    idle();
    op(osc_pkg::OP_PRINT, 4'h1, 1'b0, 48'h0, 1'b0);
    chk(instReady, 1'b1);
    while (carriageMoving !== 1'b1 && cyc < 19000) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    op(osc_pkg::OP_HOME_FIRST, 4'h0, 1'b1, 48'h0, 1'b0);
    chk(firstIdx, COLS[{mv, 2'b00} +: 4]);
    idle();
    @(posedge sys_clk);
    selectorFitted <= 1'b1;
    op(osc_pkg::OP_PRINT, 4'h1, 1'b0, 48'h0, 1'b0);
    chk(instReady, 1'b0);
    op(osc_pkg::OP_HOME_SECOND, 4'h0, 1'b1, 48'h0, 1'b0);
    chk(secondIdx, COLS[{mv, 2'b00} +: 4]);
    give_verdict();
  end
endmodule
